// [design/sensor_ctrl_defines.svh]
// Constants for the sensor serial control and frame trigger block
// Behaviour
// - Command is one control bit, 7-bit address, then 8 data bits.
// - Control bit 0 on the serial input marks a register read.
// - On a read, data leaves MSB first right after address LSB.
// - Serial input is sampled on each rising serial clock edge.
// - Enable held high lets commands follow back to back in a burst.
// - Idle-only registers change only while idle with no read-out running, or in overhead period.
// - Writes to read-only registers 88, 89 and 90 are ignored.
// - Falling edge of system reset restores every register default; the drop flag in register 90 is not cleared by it.
// - Bit 0 of register 40 selects internal (0) or external (1) mode.
// - Registers 54-55 give frames per request; spacing gives full rate.
// - Internal mode: request level starts exposure, count, overhead, read-out.
// - Internal mode delays exposure so read-outs never overlap.
// - External mode: group A starts exposure, request starts overhead.
// - Group B input drives second pixel group; both inputs level sensitive.
`ifndef SENSOR_CTRL_DEFINES_SVH
`define SENSOR_CTRL_DEFINES_SVH

// ==========================================================
// Register map
`define REG_MODE 7'h28
`define REG_EXP0 7'h29
`define REG_EXP1 7'h2A
`define REG_EXP2 7'h2B
`define REG_FRM_LO 7'h36
`define REG_FRM_HI 7'h37
`define REG_GATE 7'h7B
`define REG_TEMP_LO 7'h58
`define REG_TEMP_HI 7'h59
`define REG_STATUS 7'h5A

// ==========================================================
// Reset values
`define DEF_MODE 8'h00
`define DEF_EXP 24'h000100
`define DEF_FRAMES 16'h0001
`define DEF_GATE 8'h00

// ==========================================================
// Status register bits
`define ST_BUSY_BIT 0
`define ST_READ_BIT 1
`define ST_DROP_BIT 2
`define ST_MODE_BIT 3

// ==========================================================
// Timing
`define CLK_NS 20
`define OVH_NS 20000
`define OVH_CYC ((`OVH_NS + `CLK_NS - 1) / `CLK_NS)
`define READOUT_NS 1000000
`define READOUT_CYC ((`READOUT_NS + `CLK_NS - 1) / `CLK_NS)
`define CMD_BITS 5'h10
`define ADDR_LAST 5'h07

`endif

// [design/sensor_ctrl_pkg.sv]
// Types shared by the sensor control block
package sensor_ctrl_pkg;

    // Frame sequencer phases
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXPOSE = 3'b010,
        ST_OVERHEAD = 3'b100
    } seq_state_t;

    // Synchronised pin group
    typedef struct packed {
        logic spi_clk;
        logic spi_en;
        logic spi_in;
        logic freq;
        logic grp_a;
        logic grp_b;
        logic sys_rst_n;
    } pins_t;

    // Register store write port
    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] data;
    } wr_port_t;

    // Sequencer status seen outside
    typedef struct packed {
        logic exposing_a;
        logic exposing_b;
        logic overhead;
        logic readout;
    } seq_status_t;

endpackage

// [design/reg_store.sv]
// Register storage with registered read data
`timescale 1ns/10ps
`default_nettype none
module reg_store #(
    parameter int AW = 7,
    parameter int DW = 8
) (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [DW-1:0] wdata_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [DW-1:0] rdata_o
);
    logic [DW-1:0] mem_r [0:(1<<AW)-1];

    // ==========================================================
    // Write and registered read; contents are set by the sweep after reset
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_r[waddr_i] <= wdata_i;
        end
        rdata_o <= mem_r[raddr_i];
    end
endmodule
`default_nettype wire

// [design/sensor_ctrl.sv]
// Serial register port and frame sequencer of the image sensor front end
`timescale 1ns/10ps
`default_nettype none
`include "sensor_ctrl_defines.svh"
module sensor_ctrl #(
    parameter int unsigned OVH_CYCLES = `OVH_CYC,
    parameter int unsigned READOUT_CYCLES = `READOUT_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic system_reset_n_i,
    input wire logic spi_en_i,
    input wire logic spi_clk_i,
    input wire logic spi_in_i,
    input wire logic frame_req_i,
    input wire logic exposure_group_a_pulse_i,
    input wire logic exposure_group_b_pulse_i,
    input wire logic [15:0] temperature_i,
    output logic spi_out_o,
    output logic clock_gate_o,
    output sensor_ctrl_pkg::seq_status_t seq_status_o
);
    import sensor_ctrl_pkg::*;

    localparam logic [23:0] OVH_LD = 24'(OVH_CYCLES);
    localparam logic [23:0] RD_LD = 24'(READOUT_CYCLES);
    // Literal macros cannot be sliced directly, so give them names first
    localparam logic [7:0] DEF_MODE_V = `DEF_MODE;
    localparam logic [23:0] DEF_EXP_V = `DEF_EXP;
    localparam logic [15:0] DEF_FRAMES_V = `DEF_FRAMES;
    localparam logic [7:0] DEF_GATE_V = `DEF_GATE;

    // ==========================================================
    // Address classes
    function automatic logic is_ro(input logic [6:0] a);
        is_ro = (a == `REG_TEMP_LO) || (a == `REG_TEMP_HI) || (a == `REG_STATUS);
    endfunction

    function automatic logic is_idle_only(input logic [6:0] a);
        is_idle_only = (a >= 7'h01 && a <= 7'h26) || a == 7'h36 || a == 7'h50
            || a == 7'h52 || a == 7'h76;
    endfunction

    function automatic logic [7:0] default_of(input logic [6:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            `REG_MODE: v = DEF_MODE_V;
            `REG_EXP0: v = DEF_EXP_V[7:0];
            `REG_EXP1: v = DEF_EXP_V[15:8];
            `REG_EXP2: v = DEF_EXP_V[23:16];
            `REG_FRM_LO: v = DEF_FRAMES_V[7:0];
            `REG_FRM_HI: v = DEF_FRAMES_V[15:8];
            `REG_GATE: v = DEF_GATE_V;
            default: v = 8'h00;
        endcase
        default_of = v;
    endfunction

    // ==========================================================
    // Pin synchronisers; logic reads the second stage and its edge copy
    pins_t pins_raw;
    pins_t s1_r;
    pins_t s2_r;
    pins_t prev_r;

    assign pins_raw = '{spi_clk: spi_clk_i, spi_en: spi_en_i, spi_in: spi_in_i,
        freq: frame_req_i, grp_a: exposure_group_a_pulse_i,
        grp_b: exposure_group_b_pulse_i, sys_rst_n: system_reset_n_i};

    // Two flops per pin, plus a copy of stage two for edges
    always_ff @(posedge clk_i) begin
        s1_r <= pins_raw;
        s2_r <= s1_r;
        prev_r <= s2_r;
    end

    wire sck_rise = s2_r.spi_clk & ~prev_r.spi_clk;
    wire sck_fall = ~s2_r.spi_clk & prev_r.spi_clk;
    wire freq_rise = s2_r.freq & ~prev_r.freq;
    wire sys_fall = ~s2_r.sys_rst_n & prev_r.sys_rst_n;

    // ==========================================================
    // Serial command state
    logic [4:0] bit_cnt_r;
    logic [14:0] shift_r;
    logic [6:0] addr_r;
    logic wr_cmd_r;
    logic [7:0] out_sh_r;
    logic drop_r;
    logic sweep_r;
    logic [6:0] sweep_cnt_r;
    logic [7:0] rdata;
    logic [7:0] rd_value;
    logic quiet;
    logic [7:0] status_byte;
    wr_port_t wp;
    // Control copies and sequencer state, declared early for the status view
    logic mode_r;
    logic [23:0] exp_time_r;
    logic [15:0] frames_r;
    logic gate_r;
    seq_state_t state_r;
    seq_state_t state_nxt;
    logic [23:0] exp_cnt_r;
    logic [23:0] ovh_cnt_r;
    logic [23:0] rd_cnt_r;
    logic [15:0] frames_left_r;

    wire commit = s2_r.spi_en & sck_fall & (bit_cnt_r == `CMD_BITS);
    wire spi_wr = commit & wr_cmd_r;
    wire ro_hit = is_ro(addr_r);
    wire guard_hit = is_idle_only(addr_r) & ~quiet;
    wire wr_ok = spi_wr & ~ro_hit & ~guard_hit;
    wire load_out = s2_r.spi_en & sck_fall & (bit_cnt_r == 5'h08) & ~wr_cmd_r;
    wire status_rd = load_out & (addr_r == `REG_STATUS);

    // Serial shift; a burst simply wraps the counter while enable stays high
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !s2_r.spi_en) begin
            bit_cnt_r <= 5'h00;
            shift_r <= 15'h0000;
            addr_r <= 7'h00;
            wr_cmd_r <= 1'b0;
        end else if (sck_rise && bit_cnt_r != `CMD_BITS) begin
            shift_r <= {shift_r[13:0], s2_r.spi_in};
            bit_cnt_r <= bit_cnt_r + 5'h01;
            if (bit_cnt_r == `ADDR_LAST) begin
                addr_r <= {shift_r[5:0], s2_r.spi_in};
                wr_cmd_r <= shift_r[6];
            end
        end else if (commit) begin
            bit_cnt_r <= 5'h00;
        end
    end

    // Read data leaves on falling edges, MSB first, idle low otherwise
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !s2_r.spi_en) begin
            out_sh_r <= 8'h00;
            spi_out_o <= 1'b0;
        end else if (load_out) begin
            out_sh_r <= {rd_value[6:0], 1'b0};
            spi_out_o <= rd_value[7];
        end else if (sck_fall && bit_cnt_r > 5'h08) begin
            out_sh_r <= {out_sh_r[6:0], 1'b0};
            spi_out_o <= out_sh_r[7];
        end
    end

    // ==========================================================
    // Read-only view: temperature word and live status
    assign status_byte = {4'h0, mode_r, drop_r, rd_cnt_r != 24'h0, state_r != ST_IDLE};
    assign rd_value = (addr_r == `REG_TEMP_LO) ? temperature_i[7:0] :
        (addr_r == `REG_TEMP_HI) ? temperature_i[15:8] :
        (addr_r == `REG_STATUS) ? status_byte : rdata;

    // Sticky flag for a refused idle-only write; a new refusal beats the read clear
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            drop_r <= 1'b0;
        end else if (spi_wr && guard_hit && !ro_hit) begin
            drop_r <= 1'b1;
        end else if (status_rd) begin
            drop_r <= 1'b0;
        end
    end

    // ==========================================================
    // Default sweep after either reset; write port shared with the serial side
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || sys_fall) begin
            sweep_r <= 1'b1;
            sweep_cnt_r <= 7'h00;
        end else if (sweep_r) begin
            sweep_cnt_r <= sweep_cnt_r + 7'h01;
            sweep_r <= (sweep_cnt_r != 7'h7F);
        end
    end

    // Writes during the sweep are lost; the master must wait anyway after reset
    assign wp.we = sweep_r | wr_ok;
    assign wp.addr = sweep_r ? sweep_cnt_r : addr_r;
    assign wp.data = sweep_r ? default_of(sweep_cnt_r) : shift_r[7:0];

    reg_store #(
        .AW(7),
        .DW(8)
    ) u_store (
        .clk_i(clk_i),
        .we_i(wp.we),
        .waddr_i(wp.addr),
        .wdata_i(wp.data),
        .raddr_i(addr_r),
        .rdata_o(rdata)
    );

    // ==========================================================
    // Control copies that steer the sequencer
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mode_r <= DEF_MODE_V[0];
            exp_time_r <= DEF_EXP_V;
            frames_r <= DEF_FRAMES_V;
            gate_r <= DEF_GATE_V[0];
        end else if (wp.we) begin
            if (wp.addr == `REG_MODE) mode_r <= wp.data[0];
            if (wp.addr == `REG_EXP0) exp_time_r[7:0] <= wp.data;
            if (wp.addr == `REG_EXP1) exp_time_r[15:8] <= wp.data;
            if (wp.addr == `REG_EXP2) exp_time_r[23:16] <= wp.data;
            if (wp.addr == `REG_FRM_LO) frames_r[7:0] <= wp.data;
            if (wp.addr == `REG_FRM_HI) frames_r[15:8] <= wp.data;
            if (wp.addr == `REG_GATE) gate_r <= wp.data[0];
        end
    end

    // ==========================================================
    // Frame sequencer; counters freeze while the input clock is gated
    wire run = ~gate_r;
    wire ext = mode_r;
    wire fits = ({1'b0, exp_time_r} + {1'b0, OVH_LD}) >= {1'b0, rd_cnt_r};
    wire trig = ~ext & s2_r.freq & (state_r == ST_IDLE) & (frames_left_r == 16'h0);
    wire int_start = ~ext & (state_r == ST_IDLE) & (frames_left_r != 16'h0) & fits;
    wire ext_start = ext & (state_r == ST_IDLE) & s2_r.grp_a;
    wire exp_done = ~ext & (state_r == ST_EXPOSE) & (exp_cnt_r <= 24'h1);
    wire ext_ovh = ext & freq_rise;
    wire ovh_done = (state_r == ST_OVERHEAD) & (ovh_cnt_r <= 24'h1);

    assign quiet = (state_r == ST_OVERHEAD) | ((state_r == ST_IDLE) & (rd_cnt_r == 24'h0));

    // Next phase; an external request overrides every other phase
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: if (int_start || ext_start) state_nxt = ST_EXPOSE;
            ST_EXPOSE: if (exp_done) state_nxt = ST_OVERHEAD;
            ST_OVERHEAD: if (ovh_done) state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
        if (ext_ovh) state_nxt = ST_OVERHEAD;
    end

    // Phase register and frame budget
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || sweep_r) begin
            state_r <= ST_IDLE;
            frames_left_r <= 16'h0;
        end else if (run) begin
            state_r <= state_nxt;
            if (trig) frames_left_r <= frames_r;
            else if (int_start) frames_left_r <= frames_left_r - 16'h1;
        end
    end

    // Exposure, overhead and read-out countdowns
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || sweep_r) begin
            exp_cnt_r <= 24'h0;
            ovh_cnt_r <= 24'h0;
            rd_cnt_r <= 24'h0;
        end else if (run) begin
            if (int_start) exp_cnt_r <= exp_time_r;
            else if (exp_cnt_r != 24'h0) exp_cnt_r <= exp_cnt_r - 24'h1;
            if (state_r != ST_OVERHEAD && state_nxt == ST_OVERHEAD) ovh_cnt_r <= OVH_LD;
            else if (ovh_cnt_r != 24'h0) ovh_cnt_r <= ovh_cnt_r - 24'h1;
            if (ovh_done && state_nxt == ST_IDLE) rd_cnt_r <= RD_LD;
            else if (rd_cnt_r != 24'h0) rd_cnt_r <= rd_cnt_r - 24'h1;
        end
    end

    // ==========================================================
    // Registered outputs; group B follows its own level in external mode
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            seq_status_o <= '0;
            clock_gate_o <= 1'b0;
        end else begin
            seq_status_o.exposing_a <= state_r == ST_EXPOSE;
            seq_status_o.exposing_b <= (state_r == ST_EXPOSE) & (~ext | s2_r.grp_b);
            seq_status_o.overhead <= state_r == ST_OVERHEAD;
            seq_status_o.readout <= rd_cnt_r != 24'h0;
            clock_gate_o <= gate_r;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_ro_write_block: assert property (wp.we && !sweep_r |-> !is_ro(wp.addr))
        else $error("write reached a read-only register");
    a_idle_only_gate: assert property (wp.we && !sweep_r && is_idle_only(wp.addr)
        |-> quiet)
        else $error("idle-only register written while busy");
    a_sys_reset_sweep: assert property (sys_fall |=> sweep_r ##128 !sweep_r)
        else $error("default sweep did not run after system reset");
    a_expose_to_ovh: assert property (run && exp_done && !ext_ovh && !sweep_r
        |=> state_r == ST_OVERHEAD && ovh_cnt_r == OVH_LD)
        else $error("exposure end did not enter overhead");
    a_ext_req_ovh: assert property (run && ext_ovh && !sweep_r
        |=> state_r == ST_OVERHEAD)
        else $error("external request did not start overhead");
    a_no_overlap: assert property (run && int_start |-> fits)
        else $error("exposure start would overlap read-out");
    a_read_msb_first: assert property (load_out |=> spi_out_o == $past(rd_value[7]))
        else $error("read data MSB not driven first");
    a_rise_sample: assert property (s2_r.spi_en && sck_rise && bit_cnt_r != `CMD_BITS
        |=> shift_r[0] == $past(s2_r.spi_in))
        else $error("serial input not sampled on rising edge");
    a_mode_select: assert property (wp.we && wp.addr == `REG_MODE
        |=> mode_r == $past(wp.data[0]))
        else $error("mode bit not taken from register 40");
    a_frames_load: assert property (run && trig && !sweep_r
        |=> frames_left_r == $past(frames_r))
        else $error("frame count not loaded on request");
    a_gate_freeze: assert property (gate_r && state_r == ST_EXPOSE
        |=> $stable(exp_cnt_r))
        else $error("exposure counted while clock gated");

    c_spi_write: cover property (wr_ok);
    c_spi_read: cover property (load_out);
    c_int_frame: cover property (int_start ##[1:1000] state_r == ST_OVERHEAD);
    c_ext_frame: cover property (ext_start ##[1:1000] ext_ovh);
endmodule
`default_nettype wire

// [dv/spi_host.sv]
// Serial master model standing in for the host controller
`timescale 1ns/10ps
`default_nettype none
module spi_host (
    input wire logic clk_i,
    output logic spi_en_o,
    output logic spi_clk_o,
    output logic spi_in_o,
    input wire logic spi_out_i
);
    // ==========================================================
    // Bus state
    // Serial clock parks low between frames
    initial begin
        spi_en_o = 1'b0;
        spi_clk_o = 1'b0;
        spi_in_o = 1'b0;
    end

    // Wait some system clocks, landing just after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // One command; keep leaves the enable up for a burst
    task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] wdat,
                        input logic keep, output logic [7:0] rdat);
        logic [15:0] word;
        word = {wr, addr, wdat};
        rdat = 8'h00;
        if (!spi_en_o) begin
            spi_en_o = 1'b1;
            tick(4);
        end
        for (int i = 15; i >= 0; i--) begin
            spi_in_o = word[i];
            tick(4);
            spi_clk_o = 1'b1;
            tick(3);
            // Late in the high phase, to ride out the pin sync delay
            if (i < 8) rdat[i] = spi_out_i;
            tick(1);
            spi_clk_o = 1'b0;
        end
        if (!keep) begin
            tick(8);
            spi_en_o = 1'b0;
            // Deselected line shows the inverse so stale data never matches
            spi_in_o = ~spi_in_o;
        end
    endtask
endmodule
`default_nettype wire

// [dv/tb.sv]
// Self-checking bench for the sensor serial control and frame trigger block
`timescale 1ns/10ps
`default_nettype none
module tb;
    import sensor_ctrl_pkg::*;
    // ==========================================================
    // Signals
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic system_reset_n = 1'b1;
    logic frame_req = 1'b0;
    logic grp_a = 1'b0;
    logic grp_b = 1'b0;
    logic [15:0] temperature = 16'hA55A;
    logic spi_en;
    logic spi_clk;
    logic spi_in;
    logic spi_out;
    logic clock_gate;
    seq_status_t status;
    logic [7:0] rd;
    logic exp_q = 1'b0;
    int fails = 0;
    int check_count = 0;
    int starts = 0;
    int base;
    logic [6:0] def_a [7] = '{7'h28, 7'h29, 7'h2A, 7'h2B, 7'h36, 7'h37, 7'h7B};
    logic [7:0] def_v [7] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00};

    // 50 MHz system clock
    always #10 clk_i = ~clk_i;

    sensor_ctrl #(.OVH_CYCLES(20), .READOUT_CYCLES(200)) sensor_ctrl_inst (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .system_reset_n_i(system_reset_n),
        .spi_en_i(spi_en),
        .spi_clk_i(spi_clk),
        .spi_in_i(spi_in),
        .frame_req_i(frame_req),
        .exposure_group_a_pulse_i(grp_a),
        .exposure_group_b_pulse_i(grp_b),
        .temperature_i(temperature),
        .spi_out_o(spi_out),
        .clock_gate_o(clock_gate),
        .seq_status_o(status)
    );

    spi_host spi_host_inst (
        .clk_i(clk_i),
        .spi_en_o(spi_en),
        .spi_clk_o(spi_clk),
        .spi_in_o(spi_in),
        .spi_out_i(spi_out)
    );

    // Counts exposure starts while commands run alongside
    always @(posedge clk_i) begin
        exp_q <= status.exposing_a;
        if (status.exposing_a && !exp_q) starts <= starts + 1;
    end

    // ==========================================================
    // Helpers
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] x;
        spi_host_inst.xfer(1'b1, a, d, 1'b0, x);
    endtask

    task automatic rdc(input logic [6:0] a, input logic [7:0] e);
        spi_host_inst.xfer(1'b0, a, 8'h00, 1'b0, rd);
        chk({8'h00, rd}, {8'h00, e});
    endtask

    // Bounded wait for one status bit; running out ends the run
    task automatic wait_st(input int idx, input logic v);
        int n;
        n = 0;
        while (status[idx] !== v && n < 5000) begin
            spi_host_inst.tick(1);
            n++;
        end
        chk({15'h0, status[idx]}, {15'h0, v});
        if (n == 5000) close_out();
    endtask

    task automatic check_defaults();
        foreach (def_a[i]) rdc(def_a[i], def_v[i]);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        spi_host_inst.tick(3);
        rst_n_i = 1'b1;
        // Default sweep must finish before the first command
        spi_host_inst.tick(140);
        check_defaults();
        // Burst of writes closed by a read; exposure becomes 512 cycles
        spi_host_inst.xfer(1'b1, 7'h36, 8'h02, 1'b1, rd);
        spi_host_inst.xfer(1'b1, 7'h2A, 8'h02, 1'b1, rd);
        spi_host_inst.xfer(1'b1, 7'h29, 8'h00, 1'b1, rd);
        spi_host_inst.xfer(1'b0, 7'h36, 8'h00, 1'b0, rd);
        chk({8'h00, rd}, 16'h0002);
        rdc(7'h2A, 8'h02);
        // Read-only places keep their values
        wr(7'h58, 8'hFF);
        wr(7'h59, 8'h00);
        wr(7'h5A, 8'hFF);
        rdc(7'h58, 8'h5A);
        rdc(7'h59, 8'hA5);
        rdc(7'h5A, 8'h00);
        // Temperature word is live, not latched at reset
        temperature = 16'h3CC3;
        rdc(7'h58, 8'hC3);
        rdc(7'h59, 8'h3C);
        // Gating bit reaches its output
        wr(7'h7B, 8'h01);
        chk({15'h0, clock_gate}, 16'h0001);
        wr(7'h7B, 8'h00);
        chk({15'h0, clock_gate}, 16'h0000);
        // Internal mode, two frames; idle-only write during exposure is dropped
        base = starts;
        frame_req = 1'b1;
        wait_st(3, 1'b1);
        frame_req = 1'b0;
        wr(7'h36, 8'h05);
        rdc(7'h36, 8'h02);
        spi_host_inst.xfer(1'b0, 7'h5A, 8'h00, 1'b0, rd);
        chk({15'h0, rd[2]}, 16'h0001);
        spi_host_inst.tick(2000);
        chk(16'(starts - base), 16'h0002);
        chk({12'h0, status}, 16'h0000);
        // External mode: group A starts exposure, request starts overhead
        wr(7'h28, 8'h01);
        spi_host_inst.xfer(1'b0, 7'h5A, 8'h00, 1'b0, rd);
        chk({15'h0, rd[3]}, 16'h0001);
        grp_a = 1'b1;
        grp_b = 1'b1;
        wait_st(3, 1'b1);
        wait_st(2, 1'b1);
        grp_b = 1'b0;
        wait_st(2, 1'b0);
        frame_req = 1'b1;
        wait_st(1, 1'b1);
        frame_req = 1'b0;
        grp_a = 1'b0;
        wait_st(0, 1'b1);
        spi_host_inst.tick(400);
        chk({12'h0, status}, 16'h0000);
        // System reset pin restores the defaults
        wr(7'h36, 8'h07);
        system_reset_n = 1'b0;
        spi_host_inst.tick(4);
        system_reset_n = 1'b1;
        spi_host_inst.tick(200);
        check_defaults();
        close_out();
    end
endmodule
`default_nettype wire
